// ### src/dpspi_regs.svh
// Register map, field positions, reset values and timing of the pot SPI port
`ifndef DPSPI_REGS_SVH
`define DPSPI_REGS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define DPSPI_ADDR_POT0        4'h0
`define DPSPI_ADDR_POT1        4'h1
`define DPSPI_ADDR_LAST        4'h6
`define DPSPI_ADDR_ACCESS_CTRL 4'h8
`define DPSPI_ADDR_FIRST       4'h0

// ****************************************************************
// Instruction byte
// ****************************************************************
`define DPSPI_OP_READ          4'hB
`define DPSPI_OP_WRITE         4'hC
`define DPSPI_OP_MSB           7
`define DPSPI_OP_LSB           4
`define DPSPI_ADDR_MSB         3
`define DPSPI_ADDR_LSB         0

// ****************************************************************
// Access control fields and reset values
// ****************************************************************
`define DPSPI_BIT_BANK         7
`define DPSPI_BIT_SHUTDOWN_CONTROL         6
`define DPSPI_RST_BANK         1'b0
`define DPSPI_RST_SHUTDOWN_CONTROL         1'b1
`define DPSPI_ACR_LOW_ZERO     5'h00
`define DPSPI_RST_WIPER        8'h40
`define DPSPI_RST_POWER_UP     8'h40
`define DPSPI_UNMAPPED_DATA    8'h00
`define DPSPI_ID_DEFAULT       8'h3A

// ****************************************************************
// Serial framing and timing
// ****************************************************************
`define DPSPI_BIT_FIRST        3'h0
`define DPSPI_BIT_LAST         3'h7
`define DPSPI_NV_WRITE_MS      20
`define DPSPI_CLK_MHZ          100
`define DPSPI_NV_WRITE_CYCLES  (`DPSPI_NV_WRITE_MS * `DPSPI_CLK_MHZ * 1000)

`endif

// ### src/dpspi_pkg.sv
// Types shared by the pot SPI port
package dpspi_pkg;

  // Pins coming from outside the clock domain
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
    logic shutdown_control_n;
  } dpspi_pins_t;

  // Writable access control fields
  typedef struct packed {
    logic bank;
    logic shutdown_control;
  } dpspi_acr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ID,
    ST_INSTR,
    ST_READ,
    ST_WRITE,
    ST_IGNORE
  } dpspi_state_t;

endpackage

// ### src/dpspi_top.sv
// SPI register port of a dual digital pot, read path with prefetch buffer
// Behaviour
// RULE1: Read is ID, instruction, then dummy bytes
// RULE2: Host samples output data on falling clock
// RULE3: Host ends a read by raising select
// RULE4: Data keeps shifting while clock runs selected
// RULE5: Pointer loads from address, advances per byte
// RULE6: Pointer wraps to zero after location six
// RULE7: Host checks pending flag before power-up readback
// RULE8: Address eight is control, zero/one pots
// RULE9: Bank bit set reaches wipers only
// RULE10: Bank bit clear reaches power-up values
// RULE11: Power-up value write also loads wiper
// RULE12: Power-up value read leaves wiper alone
// RULE13: Written power-up value restored at power-up
// RULE14: Host writes 40h to control before programming
// RULE15: Host sets bank bit before reading wiper
// RULE16: Instruction is opcode high, address low
// RULE17: Opcode 1011 reads, unknown codes invalid
// RULE18: Control bit five flags non-volatile write busy
// RULE19: Output released while select is high
// RULE20: Dummy bytes alter no register
// RULE21: Output silent during ID and instruction bytes
`timescale 1ns/1ps
`include "dpspi_regs.svh"

module dpspi_top #(
  // Identification byte; value is arbitrary
  parameter logic [7:0] DEV_ID          = `DPSPI_ID_DEFAULT,
  parameter int         NV_WRITE_CYCLES = `DPSPI_NV_WRITE_CYCLES,
  parameter int         FIFO_WIDTH      = 8,
  parameter int         FIFO_DEPTH      = 2
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 recall_i,
  // Serial pins
  input  wire dpspi_pkg::dpspi_pins_t pins_i,
  output logic                      sdo_o,
  output logic                      sdo_oe_o,
  // Pot side
  output logic [7:0]                wiper0_o,
  output logic [7:0]                wiper1_o,
  output logic                      shutdown_o,
  output logic                      nv_write_pending_o
);
  import dpspi_pkg::*;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int NW = $clog2(NV_WRITE_CYCLES + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(FIFO_DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);
  localparam logic [NW-1:0] NV_LOAD  = NW'(NV_WRITE_CYCLES);

  // ****************************************************************
  // Pin synchronisers and edge finding
  // ****************************************************************
  localparam dpspi_pins_t PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1,
                                        sdi: 1'b0, shutdown_control_n: 1'b1};
  dpspi_pins_t pin1_reg;
  dpspi_pins_t pin2_reg;
  dpspi_pins_t pin3_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin1_reg <= PINS_IDLE;
      pin2_reg <= PINS_IDLE;
      pin3_reg <= PINS_IDLE;
    end else begin
      pin1_reg <= pins_i;
      pin2_reg <= pin1_reg;
      pin3_reg <= pin2_reg;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;

  assign sck_rise = pin2_reg.sck & ~pin3_reg.sck;
  assign sck_fall = ~pin2_reg.sck & pin3_reg.sck;
  assign cs_fall  = ~pin2_reg.cs_n & pin3_reg.cs_n;
  assign cs_rise  = pin2_reg.cs_n & ~pin3_reg.cs_n;
  assign selected = ~pin2_reg.cs_n;

  // ****************************************************************
  // Two-entry read prefetch buffer
  // ****************************************************************
  // Register reads run ahead of the shifter; a slow clock stalls the fill
  logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]         wr_ptr_reg;
  logic [PW-1:0]         wr_ptr_next;
  logic [PW-1:0]         rd_ptr_reg;
  logic [PW-1:0]         rd_ptr_next;
  logic [CW-1:0]         count_reg;
  logic [CW-1:0]         count_next;
  logic                  push_valid;
  logic                  push_ready;
  logic [FIFO_WIDTH-1:0] push_data;
  logic                  pop_valid;
  logic                  pop_ready;
  logic [FIFO_WIDTH-1:0] pop_data;
  logic                  push_fire;
  logic                  pop_fire;

  assign push_ready = (count_reg != CNT_FULL);
  assign pop_valid  = (count_reg != '0);
  assign pop_data   = fifo_mem[rd_ptr_reg];
  assign push_fire  = push_valid & push_ready;
  assign pop_fire   = pop_valid & pop_ready;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (!selected) begin
      // Stale prefetch must not leak into the next frame
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end else begin
      if (push_fire) begin
        wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop_fire) begin
        rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
      if (push_fire && !pop_fire) begin
        count_next = CW'(count_reg + 1'b1);
      end else if (pop_fire && !push_fire) begin
        count_next = CW'(count_reg - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_fire) begin
      fifo_mem[wr_ptr_reg] <= push_data;
    end
  end

  // ****************************************************************
  // Serial protocol and register file
  // ****************************************************************
  dpspi_state_t state_reg;
  dpspi_state_t state_next;
  logic [2:0]   bit_cnt_reg;
  logic [2:0]   bit_cnt_next;
  logic [7:0]   rx_reg;
  logic [7:0]   rx_next;
  logic [3:0]   ptr_reg;
  logic [3:0]   ptr_next;
  logic [7:0]   wiper_reg [2];
  logic [7:0]   wiper_next [2];
  logic [7:0]   nv_reg [2];
  logic [7:0]   nv_next [2];
  dpspi_acr_t   acr_reg;
  dpspi_acr_t   acr_next;
  logic [NW-1:0] pend_reg;
  logic [NW-1:0] pend_next;
  logic         dirty_reg;
  logic         dirty_next;
  logic [7:0]   tx_reg;
  logic [7:0]   tx_next;
  logic [2:0]   tx_cnt_reg;
  logic [2:0]   tx_cnt_next;
  logic         tx_on_reg;
  logic         tx_on_next;
  logic         sdo_oe_reg;
  logic         sdo_oe_next;
  logic         shut_reg;
  logic         shut_next;
  logic         pending;
  logic [7:0]   rd_data;

  assign pending = (pend_reg != '0);

  function automatic logic [3:0] ptr_advance(input logic [3:0] a);
    // Past the last location, control included, reads start over
    ptr_advance = (a >= `DPSPI_ADDR_LAST) ? `DPSPI_ADDR_FIRST
                                         : 4'(a + 4'h1); // see RULE6
  endfunction

  always_comb begin
    // Read mux follows the bank bit
    unique case (ptr_reg)
      `DPSPI_ADDR_POT0,
      `DPSPI_ADDR_POT1:
        rd_data = acr_reg.bank ? wiper_reg[ptr_reg[0]]  // see RULE9
                               : nv_reg[ptr_reg[0]];    // see RULE10
      `DPSPI_ADDR_ACCESS_CTRL:
        rd_data = {acr_reg.bank, acr_reg.shutdown_control, pending,
                   `DPSPI_ACR_LOW_ZERO};                // see RULE8 RULE18
      default:
        rd_data = `DPSPI_UNMAPPED_DATA;
    endcase
  end

  assign push_valid = (state_reg == ST_READ) & selected;
  assign push_data  = rd_data;
  assign pop_ready  = selected & ~cs_fall & sck_fall &
                      (state_reg == ST_READ) &
                      (tx_cnt_reg == `DPSPI_BIT_FIRST);

  always_comb begin
    state_next  = state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_next     = rx_reg;
    ptr_next    = ptr_reg;
    wiper_next  = wiper_reg;
    nv_next     = nv_reg;
    acr_next    = acr_reg;
    pend_next   = pend_reg;
    dirty_next  = dirty_reg;
    tx_next     = tx_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_on_next  = tx_on_reg;
    shut_next   = ~(acr_reg.shutdown_control | pin2_reg.shutdown_control_n);

    if (pending) begin
      pend_next = NW'(pend_reg - 1'b1);
    end
    // Programming time starts when the frame closes
    if (cs_rise && dirty_reg) begin
      pend_next  = NV_LOAD;                             // see RULE18
      dirty_next = 1'b0;
    end
    if (recall_i) begin
      wiper_next = nv_reg;                              // see RULE13
    end
    // Pointer moves as each byte enters the buffer
    if (push_fire) begin
      ptr_next = ptr_advance(ptr_reg);                  // see RULE5
    end

    if (!selected) begin
      state_next = ST_IDLE;
      tx_on_next = 1'b0;                                // see RULE19
    end else if (cs_fall) begin
      state_next   = ST_ID;                             // see RULE1
      bit_cnt_next = `DPSPI_BIT_FIRST;
      tx_cnt_next  = `DPSPI_BIT_FIRST;
      tx_on_next   = 1'b0;                              // see RULE21
    end else begin
      if (sck_rise) begin
        rx_next      = {rx_reg[6:0], pin2_reg.sdi};
        bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
        if (bit_cnt_reg == `DPSPI_BIT_LAST) begin
          unique case (state_reg)
            ST_ID:
              state_next = (rx_next == DEV_ID) ? ST_INSTR : ST_IGNORE;
            ST_INSTR: begin
              ptr_next = rx_next[`DPSPI_ADDR_MSB:`DPSPI_ADDR_LSB]; // see RULE16
              unique case (rx_next[`DPSPI_OP_MSB:`DPSPI_OP_LSB])
                `DPSPI_OP_READ:  state_next = ST_READ;   // see RULE17
                `DPSPI_OP_WRITE: state_next = ST_WRITE;
                default:         state_next = ST_IGNORE;
              endcase
            end
            ST_WRITE: begin
              // Busy programming locks every register
              if (!pending) begin
                unique case (ptr_reg)
                  `DPSPI_ADDR_POT0,
                  `DPSPI_ADDR_POT1: begin
                    wiper_next[ptr_reg[0]] = rx_next;     // see RULE9 RULE11
                    if (!acr_reg.bank) begin
                      nv_next[ptr_reg[0]] = rx_next;      // see RULE10 RULE13
                      dirty_next = 1'b1;
                    end
                  end
                  `DPSPI_ADDR_ACCESS_CTRL: begin
                    acr_next.bank = rx_next[`DPSPI_BIT_BANK];
                    acr_next.shutdown_control = rx_next[`DPSPI_BIT_SHUTDOWN_CONTROL];
                  end
                  default: ;
                endcase
              end
              ptr_next = ptr_advance(ptr_reg);
            end
            // Dummy bytes of a read are dropped here
            default: ;                                    // see RULE20
          endcase
        end
      end
      if (sck_fall && state_reg == ST_READ) begin
        tx_cnt_next = 3'(tx_cnt_reg + 3'h1);              // see RULE4
        if (tx_cnt_reg == `DPSPI_BIT_FIRST) begin
          // Empty buffer releases the line rather than send junk
          tx_next    = pop_valid ? pop_data : '1;         // see RULE12
          tx_on_next = 1'b1;                              // see RULE21
        end else begin
          tx_next = {tx_reg[6:0], 1'b1};
        end
      end
    end
    // Open drain: pull low only for a zero bit
    sdo_oe_next = tx_on_next & ~tx_next[7] & selected;   // see RULE19
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= `DPSPI_BIT_FIRST;
      rx_reg      <= '0;
      ptr_reg     <= `DPSPI_ADDR_FIRST;
      wiper_reg   <= '{default: `DPSPI_RST_WIPER};
      nv_reg      <= '{default: `DPSPI_RST_POWER_UP};
      acr_reg     <= '{bank: `DPSPI_RST_BANK, shutdown_control: `DPSPI_RST_SHUTDOWN_CONTROL};
      pend_reg    <= '0;
      dirty_reg   <= 1'b0;
      tx_reg      <= '1;
      tx_cnt_reg  <= `DPSPI_BIT_FIRST;
      tx_on_reg   <= 1'b0;
      sdo_oe_reg  <= 1'b0;
      shut_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg      <= rx_next;
      ptr_reg     <= ptr_next;
      wiper_reg   <= wiper_next;
      nv_reg      <= nv_next;
      acr_reg     <= acr_next;
      pend_reg    <= pend_next;
      dirty_reg   <= dirty_next;
      tx_reg      <= tx_next;
      tx_cnt_reg  <= tx_cnt_next;
      tx_on_reg   <= tx_on_next;
      sdo_oe_reg  <= sdo_oe_next;
      shut_reg    <= shut_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sdo_o              = 1'b0;
  assign sdo_oe_o           = sdo_oe_reg;
  assign wiper0_o           = wiper_reg[0];
  assign wiper1_o           = wiper_reg[1];
  assign shutdown_o         = shut_reg;
  assign nv_write_pending_o = pending;

endmodule

// ### bench/dpspi_top_sva.sv
// Checker for the pot SPI port
`timescale 1ns/1ps
module dpspi_top_sva #(
  parameter int NV_WRITE_CYCLES = 50
) (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   recall_i,
  // Serial pins
  input wire dpspi_pkg::dpspi_pins_t pins_i,
  input wire logic                   sdo_o,
  input wire logic                   sdo_oe_o,
  // Pot side
  input wire logic [7:0]             wiper0_o,
  input wire logic [7:0]             wiper1_o,
  input wire logic                   shutdown_o,
  input wire logic                   nv_write_pending_o
);
  import dpspi_pkg::*;
  logic sck_reg, sck_next, cs_reg, cs_next;
  int   age_reg, age_next, rise_reg, rise_next, pend_reg, pend_next;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counted on raw pins, so sync delay sits inside the bounds
  always_comb begin
    sck_next  = pins_i.sck;
    cs_next   = pins_i.cs_n;
    age_next  = (age_reg < 15) ? age_reg + 1 : age_reg;
    if ((sck_reg && !pins_i.sck) || (!cs_reg && pins_i.cs_n)) begin
      age_next = 0;
    end
    rise_next = rise_reg;
    if (pins_i.cs_n) begin
      rise_next = 0;
    end else if (!sck_reg && pins_i.sck && rise_reg < 16) begin
      rise_next = rise_reg + 1;
    end
    pend_next = nv_write_pending_o ? pend_reg + 1 : 0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_reg  <= 1'b0;
      cs_reg   <= 1'b1;
      age_reg  <= 0;
      rise_reg <= 0;
      pend_reg <= 0;
    end else begin
      sck_reg  <= sck_next;
      cs_reg   <= cs_next;
      age_reg  <= age_next;
      rise_reg <= rise_next;
      pend_reg <= pend_next;
    end
  end
  sequence cs_idle;
    pins_i.cs_n [*6];
  endsequence
  property reset_state;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> !sdo_oe_o && wiper0_o == 8'h40 && wiper1_o == 8'h40
      && !nv_write_pending_o && !shutdown_o;
  endproperty
  reset_state_a: assert property (reset_state)
    else $error("state after reset wrong");
  release_idle_a: assert property (cs_idle |-> !sdo_oe_o)
    else $error("data line driven while deselected");
  drain_low_a: assert property (sdo_oe_o |-> sdo_o == 1'b0)
    else $error("open drain pin drives high");
  silent_head_a: assert property (!pins_i.cs_n && rise_reg < 16 |-> !sdo_oe_o)
    else $error("data line driven in header bytes");
  shift_timing_a: assert property ($changed(sdo_oe_o) |-> age_reg inside {[1:6]})
    else $error("data bit changed away from clock fall");
  wiper_quiet_a: assert property (!$stable({wiper0_o, wiper1_o}) |->
    !pins_i.cs_n || $past(recall_i) || $past(recall_i, 2))
    else $error("wiper changed outside a frame");
  pend_start_a: assert property ($rose(nv_write_pending_o) |-> pins_i.cs_n)
    else $error("pending set while selected");
  pend_len_a: assert property ($fell(nv_write_pending_o) |->
    pend_reg inside {[NV_WRITE_CYCLES - 1:NV_WRITE_CYCLES + 1]})
    else $error("pending length wrong");
endmodule
bind dpspi_top dpspi_top_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dpspi_top_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .recall_i(recall_i), .pins_i(pins_i),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .wiper0_o(wiper0_o),
  .wiper1_o(wiper1_o), .shutdown_o(shutdown_o),
  .nv_write_pending_o(nv_write_pending_o)
);

// ### bench/dpspi_host_model.sv
// SPI host model, mode 0, pull-up on the data line
`timescale 1ns/1ps
module dpspi_host_model (
  // Clock
  input  wire logic              clk_i,
  // Pins
  input  wire logic              shutdown_control_n_i,
  input  wire logic              sdo_oe_i,
  output dpspi_pkg::dpspi_pins_t pins_o
);
  import dpspi_pkg::*;
  logic sck  = 1'b0;
  logic cs_n = 1'b1;
  logic sdi  = 1'b0;
  // Half period in clocks; raised for a slow host
  int   half = 4;
  assign pins_o = '{sck: sck, cs_n: cs_n, sdi: sdi, shutdown_control_n: shutdown_control_n_i};
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // MSB first; line sampled just before the clock falls
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      wait_clk(half);
      sck <= 1'b1;
      wait_clk(half);
      rx[i] = ~sdo_oe_i;
      sck <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] id, input logic [7:0] instr,
                       input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n <= 1'b0;
    wait_clk(half);
    xfer_byte(id, b);
    xfer_byte(instr, b);
    foreach (tx[k]) begin
      xfer_byte(tx[k], b);
      rx.push_back(b);
    end
    wait_clk(half);
    cs_n <= 1'b1;
    // Released input must not look like held data
    sdi  <= ~sdi;
    wait_clk(8);
  endtask
endmodule

// ### bench/dpspi_top_bench.sv
// Self-checking bench for the pot SPI port
`timescale 1ns/1ps
module dpspi_top_bench;
  import dpspi_pkg::*;
  // Identification byte; value is arbitrary
  localparam logic [7:0] DEV_ID = 8'hA6;
  logic        clk = 1'b0;
  logic        rst, recall, shutdown_control_n, sdo, sdo_oe, shutdown, pending;
  logic [7:0]  wiper0, wiper1;
  wire dpspi_pins_t pins;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #5 clk = ~clk;
  dpspi_host_model host_i (
    .clk_i(clk), .shutdown_control_n_i(shutdown_control_n), .sdo_oe_i(sdo_oe), .pins_o(pins)
  );
  dpspi_top #(.DEV_ID(DEV_ID), .NV_WRITE_CYCLES(400)) dpspi_top_i (
    .clk_i(clk), .rst_i(rst), .recall_i(recall), .pins_i(pins),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .wiper0_o(wiper0), .wiper1_o(wiper1),
    .shutdown_o(shutdown), .nv_write_pending_o(pending)
  );
  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Nonzero dummies, so a leak into a register shows
  task automatic rd(input logic [3:0] a, input int n, output logic [7:0] q[$]);
    logic [7:0] d[$];
    d = {};
    repeat (n) d.push_back(8'hC3);
    host_i.frame(DEV_ID, {4'hB, a}, d, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] q[$];
    host_i.frame(DEV_ID, {4'hC, a}, {v}, q);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] q[$];
    logic [7:0] exp[$];
    rst    <= 1'b1;
    recall <= 1'b0;
    shutdown_control_n <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(wiper0, 8'h40);
    check({6'h0, shutdown, pending}, 8'h00);
    rd(4'h8, 1, q);
    check(q[0], 8'h40);
    wr(4'h8, 8'h80);
    wr(4'h1, 8'h5A);
    check({7'h0, pending}, 8'h00);
    check(wiper1, 8'h5A);
    rd(4'h1, 9, q);
    exp = {8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h5A, 8'h00};
    foreach (exp[k]) check(q[k], exp[k]);
    rd(4'h8, 2, q);
    check(q[0], 8'h80);
    check(q[1], 8'h40);
    shutdown_control_n <= 1'b0;
    repeat (6) @(posedge clk);
    check({7'h0, shutdown}, 8'h01);
    shutdown_control_n <= 1'b1;
    wr(4'h8, 8'h40);
    wr(4'h0, 8'h77);
    check(wiper0, 8'h77);
    rd(4'h8, 1, q);
    check(q[0], 8'h60);
    for (int i = 0; i < 8 && q[0] !== 8'h40; i++) rd(4'h8, 1, q);
    check(q[0], 8'h40);
    wr(4'h8, 8'h80);
    wr(4'h0, 8'h11);
    wr(4'h8, 8'h40);
    rd(4'h0, 1, q);
    check(q[0], 8'h77);
    check(wiper0, 8'h11);
    recall <= 1'b1;
    @(posedge clk);
    recall <= 1'b0;
    repeat (3) @(posedge clk);
    check(wiper0, 8'h77);
    check(wiper1, 8'h40);
    for (int op = 0; op < 16; op++) begin
      if (op == 11 || op == 12) continue;
      host_i.frame(DEV_ID, {op[3:0], 4'h0}, {8'h00}, q);
      check(q[0], 8'hFF);
    end
    host_i.frame(~DEV_ID, 8'hB0, {8'h00}, q);
    check(q[0], 8'hFF);
    host_i.frame(~DEV_ID, 8'hC0, {8'h00}, q);
    check(wiper0, 8'h77);
    host_i.half = 9;
    rd(4'h0, 2, q);
    check(q[0], 8'h77);
    check(q[1], 8'h40);
    host_i.half = 4;
    end_of_test();
  end
endmodule
